// [fesseq_dev.sv]
// Flash-side erase/suspend sequencer
// Behaviour
// - 52h plus address erases one 32K block
// - D8h plus address erases one 64K block
// - C7h or 60h erases whole array
// - Erase accepted only with write enable latch set
// - Frame ending off byte boundary is discarded
// - Valid frame end starts timed operation
// - Busy high during cycle; status stays readable
// - Finished cycle clears write enable latch
// - Block erase into protected region refused
// - Chip erase refused if anything protected
// - 75h pauses sector, block erase or program
// - Erase suspended: erase commands rejected
// - Suspend ignored during chip erase
// - Program suspended: program commands rejected
// - Suspend accepted only when busy, not suspended
// - Other suspends silently ignored
// - Suspend flag at once, busy drops after latency
// - Host spaces suspend after resume by latency
// - Reset releases suspend, clears suspend flag
// - Resume clears flag, busy back within 200ns
`timescale 1ns/1ps
module fesseq_dev #(
  parameter int SECTOR_CYC = fesseq_pkg::SECTOR_ERASE_CYC,
  parameter int BLK32_CYC  = fesseq_pkg::SMALL_BLOCK_ERASE_CYC,
  parameter int BLK64_CYC  = fesseq_pkg::BLOCK_ERASE_CYC,
  parameter int CHIP_CYC   = fesseq_pkg::CHIP_ERASE_CYC,
  parameter int PROG_CYC   = fesseq_pkg::PAGE_PROG_CYC,
  parameter int SUSP_CYC   = fesseq_pkg::SUSPEND_CYC
) (
  // Clock and reset
  input  wire logic                   CLOCK_IN,
  input  wire logic                   RST_IN,
  // Serial link
  fesseq_if.dev                       LINK,
  // Protection and mode settings
  input  wire logic                   PROTECT_COMPLEMENT_IN,
  input  wire logic                   SECTOR_GRANULARITY_PROTECT_IN,
  input  wire logic                   TOP_BOTTOM_PROTECT_IN,
  input  wire logic [2:0]             BLOCK_PROTECT_IN,
  input  wire logic                   FOUR_WIRE_INSTRUCTION_MODE_IN,
  // Status flags
  output logic                        BUSY_OUT,
  output logic                        WRITE_ENABLE_LATCH_OUT,
  output logic                        SUSPEND_FLAG_OUT,
  // Erase completion
  output logic                        ERASE_DONE_OUT,
  output fesseq_pkg::fesseq_op_t      ERASE_KIND_OUT,
  output logic [23:0]                 ERASE_BASE_OUT
);
  import fesseq_pkg::*;

  logic [5:0]    sy1_r, sy2_r;
  logic          sclk_d_r, csn_d_r;
  logic          quad, csn_s, rise, fall, cs_rise, cs_fall, byte_done;
  logic [2:0]    bit_r, bit_nxt, nbytes_r;
  logic [7:0]    sh_r, sh_nxt, op_r, out_sh_r, status_byte;
  logic [23:0]   addr_r;
  logic          rd_act_r, oe_r;
  logic [3:0]    dout_r;
  fesseq_state_t state_r, state_nxt;
  fesseq_op_t    kind_r, held_kind_r, kind_nxt;
  logic [31:0]   cnt_r, held_cnt_r, dur, lat_r;
  logic [23:0]   base_r, held_base_r, ra, rb, plen, plo, phi;
  logic          busy_r, wel_r, susp_r, done_r, done;
  logic          frame_ok, len_ok, prot, conflict, start_ok, susp_ok, res_ok;
  fesseq_op_t    dkind_r;
  logic [23:0]   dbase_r;

  // Pins cross into this clock through two flops
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sy1_r    <= PIN_RST;
      sy2_r    <= PIN_RST;
      sclk_d_r <= 1'b0;
      csn_d_r  <= 1'b1;
    end else begin
      sy1_r    <= {LINK.cs_n, LINK.sclk, LINK.io_lvl};
      sy2_r    <= sy1_r;
      sclk_d_r <= sy2_r[4];
      csn_d_r  <= sy2_r[5];
    end
  end

  assign quad      = FOUR_WIRE_INSTRUCTION_MODE_IN;
  assign csn_s     = sy2_r[5];
  assign rise      = sy2_r[4] & ~sclk_d_r & ~csn_s;
  assign fall      = ~sy2_r[4] & sclk_d_r & ~csn_s;
  assign cs_rise   = csn_s & ~csn_d_r;
  assign cs_fall   = ~csn_s & csn_d_r;
  assign sh_nxt    = quad ? {sh_r[3:0], sy2_r[3:0]} : {sh_r[6:0], sy2_r[0]};
  assign bit_nxt   = bit_r + (quad ? 3'h4 : 3'h1);
  assign byte_done = rise && (bit_nxt == 3'h0);

  // Instruction, address and data byte capture
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || cs_fall) begin
      bit_r    <= 3'h0;
      nbytes_r <= 3'h0;
      sh_r     <= 8'h00;
    end else if (rise) begin
      sh_r  <= sh_nxt;
      bit_r <= bit_nxt;
      if (byte_done && nbytes_r != 3'h5) begin
        nbytes_r <= nbytes_r + 3'h1;
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      op_r   <= 8'h00;
      addr_r <= 24'h000000;
    end else if (byte_done && nbytes_r == 3'h0) begin
      op_r <= sh_nxt;
    end else if (byte_done && nbytes_r < 3'h4) begin
      addr_r <= {addr_r[15:0], sh_nxt};
    end
  end

  // Status byte reload each byte keeps polling live during a cycle
  assign status_byte = {susp_r, 5'h00, wel_r, busy_r};

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || cs_rise || cs_fall) begin
      rd_act_r <= 1'b0;
      oe_r     <= 1'b0;
      out_sh_r <= 8'h00;
      dout_r   <= 4'h0;
    end else begin
      if (byte_done && (rd_act_r || (nbytes_r == 3'h0 && sh_nxt == OP_READ_STATUS))) begin
        rd_act_r <= 1'b1;
        out_sh_r <= status_byte;
      end else if (fall && rd_act_r) begin
        oe_r     <= 1'b1;
        dout_r   <= quad ? out_sh_r[7:4] : {2'b00, out_sh_r[7], 1'b0};
        out_sh_r <= quad ? {out_sh_r[3:0], 4'h0} : {out_sh_r[6:0], 1'b0};
      end
    end
  end

  assign LINK.dev_io_out = dout_r;
  assign LINK.dev_io_oe  = oe_r ? (quad ? 4'hf : 4'h2) : 4'h0;

  // Decode of the finished frame
  always_comb begin
    kind_nxt = OPK_NONE;
    dur      = 32'h0;
    len_ok   = (nbytes_r == 3'h4);
    ra       = addr_r;
    rb       = addr_r;
    if (op_r == OP_SECTOR_ERASE) begin
      kind_nxt = OPK_SECTOR;
      dur      = 32'(SECTOR_CYC);
      ra       = addr_r & ~SECTOR_MASK;
      rb       = addr_r | SECTOR_MASK;
    end else if (op_r == OP_BLOCK32_ERASE) begin
      kind_nxt = OPK_BLK32;
      dur      = 32'(BLK32_CYC);
      ra       = addr_r & ~BLK32_MASK;
      rb       = addr_r | BLK32_MASK;
    end else if (op_r == OP_BLOCK64_ERASE) begin
      kind_nxt = OPK_BLK64;
      dur      = 32'(BLK64_CYC);
      ra       = addr_r & ~BLK64_MASK;
      rb       = addr_r | BLK64_MASK;
    end else if (op_r == OP_CHIP_ERASE_A || op_r == OP_CHIP_ERASE_B) begin
      kind_nxt = OPK_CHIP;
      dur      = 32'(CHIP_CYC);
      len_ok   = (nbytes_r == 3'h1);
      ra       = 24'h000000;
      rb       = ARRAY_BYTES - 24'h1;
    end else if (op_r == OP_PAGE_PROG || op_r == OP_QUAD_PROG || op_r == OP_SECURITY_PROG) begin
      kind_nxt = OPK_PROG;
      dur      = 32'(PROG_CYC);
      len_ok   = (nbytes_r == 3'h5);
      ra       = addr_r & ~PAGE_MASK;
      rb       = addr_r | PAGE_MASK;
    end
  end

  // Protected span, contiguous from the top or bottom of the array
  always_comb begin
    plen = (BLOCK_PROTECT_IN == 3'h0) ? 24'h0 :
           (SECTOR_GRANULARITY_PROTECT_IN ? PROT_UNIT_SG : PROT_UNIT) << (BLOCK_PROTECT_IN - 3'h1);
    if (SECTOR_GRANULARITY_PROTECT_IN && BLOCK_PROTECT_IN > 3'h4) begin
      plen = PROT_UNIT;
    end
    plo = TOP_BOTTOM_PROTECT_IN ? 24'h0 : ARRAY_BYTES - plen;
    phi = TOP_BOTTOM_PROTECT_IN ? plen - 24'h1 : ARRAY_BYTES - 24'h1;
    if (PROTECT_COMPLEMENT_IN) begin
      prot = !(plen != 24'h0 && ra >= plo && rb <= phi);
    end else begin
      prot = (plen != 24'h0) && ra <= phi && rb >= plo;
    end
  end

  assign frame_ok = cs_rise && (bit_r == 3'h0);
  assign conflict = susp_r && ((held_kind_r == OPK_PROG) ? (kind_nxt == OPK_PROG) :
                    (kind_nxt != OPK_PROG || op_r == OP_WRITE_STATUS));
  assign start_ok = frame_ok && len_ok && kind_nxt != OPK_NONE && wel_r && !conflict && !prot &&
                    (state_r == ST_IDLE || state_r == ST_SUSPENDED);
  assign susp_ok  = frame_ok && op_r == OP_SUSPEND && nbytes_r == 3'h1 && !susp_r && busy_r &&
                    state_r == ST_RUN && kind_r != OPK_CHIP;
  assign res_ok   = frame_ok && op_r == OP_RESUME && nbytes_r == 3'h1 && susp_r && !busy_r &&
                    state_r == ST_SUSPENDED;
  assign done     = state_r == ST_RUN && cnt_r == 32'h1 && !susp_ok;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_ok) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (susp_ok) begin
          state_nxt = ST_SUSPENDING;
        end else if (done) begin
          state_nxt = susp_r ? ST_SUSPENDED : ST_IDLE;
        end
      end
      ST_SUSPENDING: begin
        if (lat_r == 32'h0) begin
          state_nxt = ST_SUSPENDED;
        end
      end
      ST_SUSPENDED: begin
        if (start_ok) begin
          state_nxt = ST_RUN;
        end else if (res_ok) begin
          state_nxt = ST_RESUMING;
        end
      end
      ST_RESUMING: begin
        if (lat_r == 32'h0) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Power loss is modelled by reset: suspend released, flags cleared
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      state_r <= ST_IDLE;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy_r  <= state_nxt == ST_RUN || state_nxt == ST_SUSPENDING;
    end
  end

  // Operation timer; suspended work is parked with its remaining count
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      cnt_r       <= 32'h0;
      lat_r       <= 32'h0;
      kind_r      <= OPK_NONE;
      base_r      <= 24'h0;
      held_cnt_r  <= 32'h0;
      held_kind_r <= OPK_NONE;
      held_base_r <= 24'h0;
    end else if (start_ok) begin
      cnt_r  <= dur;
      kind_r <= kind_nxt;
      base_r <= ra;
    end else if (susp_ok) begin
      held_cnt_r  <= cnt_r;
      held_kind_r <= kind_r;
      held_base_r <= base_r;
      lat_r       <= 32'(SUSP_CYC - 1);
    end else if (res_ok) begin
      lat_r <= 32'(RESUME_CYC - 1);
    end else if (state_r == ST_RESUMING && lat_r == 32'h0) begin
      cnt_r  <= held_cnt_r;
      kind_r <= held_kind_r;
      base_r <= held_base_r;
    end else if (state_r == ST_RUN) begin
      cnt_r <= cnt_r - 32'h1;
    end else if (lat_r != 32'h0) begin
      lat_r <= lat_r - 32'h1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      susp_r <= 1'b0;
    end else if (susp_ok) begin
      susp_r <= 1'b1;
    end else if (res_ok) begin
      susp_r <= 1'b0;
    end
  end

  // Write enable only taken while busy is low (idle, suspended or resuming); no overlap with completion
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      wel_r <= 1'b0;
    end else if (done) begin
      wel_r <= 1'b0;
    end else if (frame_ok && nbytes_r == 3'h1 && !busy_r && op_r == OP_WRITE_ENABLE) begin
      wel_r <= 1'b1;
    end else if (frame_ok && nbytes_r == 3'h1 && !busy_r && op_r == OP_WRITE_DISABLE) begin
      wel_r <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      done_r  <= 1'b0;
      dkind_r <= OPK_NONE;
      dbase_r <= 24'h0;
    end else begin
      done_r <= done && kind_r != OPK_PROG;
      if (done) begin
        dkind_r <= kind_r;
        dbase_r <= base_r;
      end
    end
  end

  assign BUSY_OUT               = busy_r;
  assign WRITE_ENABLE_LATCH_OUT = wel_r;
  assign SUSPEND_FLAG_OUT       = susp_r;
  assign ERASE_DONE_OUT         = done_r;
  assign ERASE_KIND_OUT         = dkind_r;
  assign ERASE_BASE_OUT         = dbase_r;
endmodule

// [fesseq_pkg.sv]
// Shared constants and types for the erase/suspend sequencer and its host
package fesseq_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CYC_PER_US    = 1000 / CLK_PERIOD_NS;
  // Self-timed operation times
  localparam int SECTOR_ERASE_TIME_US      = 50000;
  localparam int SMALL_BLOCK_ERASE_TIME_US = 120000;
  localparam int BLOCK_ERASE_TIME_US       = 150000;
  localparam int CHIP_ERASE_TIME_US        = 10000000;
  localparam int PAGE_PROG_TIME_US         = 700;
  localparam int SUSPEND_TIME_US           = 20;
  localparam int RESUME_TIME_NS            = 200;
  localparam int SECTOR_ERASE_CYC      = SECTOR_ERASE_TIME_US * CYC_PER_US;
  localparam int SMALL_BLOCK_ERASE_CYC = SMALL_BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int BLOCK_ERASE_CYC       = BLOCK_ERASE_TIME_US * CYC_PER_US;
  localparam int CHIP_ERASE_CYC        = CHIP_ERASE_TIME_US * CYC_PER_US;
  localparam int PAGE_PROG_CYC         = PAGE_PROG_TIME_US * CYC_PER_US;
  localparam int SUSPEND_CYC           = SUSPEND_TIME_US * CYC_PER_US;
  localparam int RESUME_CYC            = RESUME_TIME_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC         = 8;
  // Instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
  localparam logic [7:0] OP_READ_STATUS    = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS   = 8'h01;
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE  = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE  = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A   = 8'hc7;
  localparam logic [7:0] OP_CHIP_ERASE_B   = 8'h60;
  localparam logic [7:0] OP_SECURITY_ERASE = 8'h44;
  localparam logic [7:0] OP_PAGE_PROG      = 8'h02;
  localparam logic [7:0] OP_QUAD_PROG      = 8'h32;
  localparam logic [7:0] OP_SECURITY_PROG  = 8'h42;
  localparam logic [7:0] OP_SUSPEND        = 8'h75;
  localparam logic [7:0] OP_RESUME         = 8'h7a;
  // Array geometry and protection unit
  localparam logic [23:0] ARRAY_BYTES  = 24'h200000;
  localparam logic [23:0] PROT_UNIT    = 24'h008000;
  localparam logic [23:0] PROT_UNIT_SG = 24'h001000;
  localparam logic [23:0] SECTOR_MASK  = 24'h000fff;
  localparam logic [23:0] BLK32_MASK   = 24'h007fff;
  localparam logic [23:0] BLK64_MASK   = 24'h00ffff;
  localparam logic [23:0] PAGE_MASK    = 24'h0000ff;
  // Status byte bit positions
  localparam int SR_BUSY_BIT = 0;
  localparam int SR_WEL_BIT  = 1;
  localparam int SR_SUSP_BIT = 7;
  // Link pin reset level {cs_n, sclk, io[3:0]}
  localparam logic [5:0] PIN_RST = 6'h2f;
  // Host register offsets
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_CFG    = 8'h10;
  typedef enum logic [2:0] {
    OPK_NONE, OPK_SECTOR, OPK_BLK32, OPK_BLK64, OPK_CHIP, OPK_PROG
  } fesseq_op_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RUN = 3'b001, ST_SUSPENDING = 3'b011,
    ST_SUSPENDED = 3'b010, ST_RESUMING = 3'b110
  } fesseq_state_t;
  typedef enum logic [1:0] {
    H_IDLE = 2'b00, H_SEND = 2'b01, H_READ = 2'b11, H_END = 2'b10
  } fesseq_hstate_t;
endpackage

// [fesseq_if.sv]
// Serial link between flash controller and flash sequencer
`timescale 1ns/1ps
interface fesseq_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] host_io_out;
  logic [3:0] host_io_oe;
  logic [3:0] dev_io_out;
  logic [3:0] dev_io_oe;
  logic [3:0] io_lvl;
  // Pull-up level when nobody drives
  assign io_lvl = (host_io_oe & host_io_out) | (~host_io_oe & dev_io_oe & dev_io_out) |
                  (~host_io_oe & ~dev_io_oe);
  modport host (output sclk, output cs_n, output host_io_out, output host_io_oe, input io_lvl);
  modport dev  (input sclk, input cs_n, input io_lvl, output dev_io_out, output dev_io_oe);
endinterface

// [fesseq_host.sv]
// Host-side flash controller with AHB-Lite command registers
`timescale 1ns/1ps
module fesseq_host #(
  parameter int HALF_CYC  = fesseq_pkg::SCLK_HALF_CYC,
  parameter int GUARD_CYC = fesseq_pkg::SUSPEND_CYC
) (
  // Clock and reset
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_IN,
  // AHB-Lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic [31:0]      HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  // Serial link
  fesseq_if.host           LINK
);
  import fesseq_pkg::*;

  logic           ap, wr_r, pend_r, quad_r, sclk_r, csn_r, tick, rd;
  logic [7:0]     wsel_r, op_r, wdata_r, rx_r, rdata_r;
  logic [23:0]    addr_r;
  logic [31:0]    hrdata_r, guard_r, div_r;
  logic [39:0]    tx_r;
  logic [5:0]     rem_r, nbits;
  logic [3:0]     sy1_r, sy2_r;
  fesseq_hstate_t st_r;

  assign ap = HSEL_IN && HTRANS_IN[1] && HREADY_IN;

  // Zero wait states; HSIZE is ignored since only words are used
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      wr_r     <= 1'b0;
      wsel_r   <= 8'h00;
      hrdata_r <= 32'h0;
    end else begin
      wr_r   <= ap && HWRITE_IN;
      wsel_r <= HADDR_IN[7:0];
      if (ap && !HWRITE_IN) begin
        if (HADDR_IN[7:0] == REG_CMD) begin
          hrdata_r <= {24'h0, op_r};
        end else if (HADDR_IN[7:0] == REG_ADDR) begin
          hrdata_r <= {8'h0, addr_r};
        end else if (HADDR_IN[7:0] == REG_WDATA) begin
          hrdata_r <= {24'h0, wdata_r};
        end else if (HADDR_IN[7:0] == REG_STATUS) begin
          hrdata_r <= {16'h0, rdata_r, 6'h0, guard_r != 32'h0, pend_r};
        end else if (HADDR_IN[7:0] == REG_CFG) begin
          hrdata_r <= {31'h0, quad_r};
        end else begin
          hrdata_r <= 32'h0;
        end
      end
    end
  end

  assign HRDATA_OUT    = hrdata_r;
  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;

  // Register writes; a command write while one is pending is dropped
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      op_r    <= 8'h00;
      addr_r  <= 24'h0;
      wdata_r <= 8'h00;
      quad_r  <= 1'b0;
    end else if (wr_r) begin
      if (wsel_r == REG_CMD && !pend_r) begin
        op_r <= HWDATA_IN[7:0];
      end else if (wsel_r == REG_ADDR) begin
        addr_r <= HWDATA_IN[23:0];
      end else if (wsel_r == REG_WDATA) begin
        wdata_r <= HWDATA_IN[7:0];
      end else if (wsel_r == REG_CFG) begin
        quad_r <= HWDATA_IN[0];
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      sy1_r <= 4'hf;
      sy2_r <= 4'hf;
    end else begin
      sy1_r <= LINK.io_lvl;
      sy2_r <= sy1_r;
    end
  end

  // Frame length: whole bytes only, address and data as the code needs
  always_comb begin
    nbits = 6'd8;
    if (op_r == OP_PAGE_PROG || op_r == OP_QUAD_PROG || op_r == OP_SECURITY_PROG) begin
      nbits = 6'd40;
    end else if (op_r == OP_SECTOR_ERASE || op_r == OP_BLOCK32_ERASE ||
                 op_r == OP_BLOCK64_ERASE || op_r == OP_SECURITY_ERASE) begin
      nbits = 6'd32;
    end
  end

  assign rd   = (op_r == OP_READ_STATUS);
  assign tick = (st_r != H_IDLE) && (div_r == 32'h0);

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN || st_r == H_IDLE || tick) begin
      div_r <= 32'(HALF_CYC - 1);
    end else begin
      div_r <= div_r - 32'h1;
    end
  end

  // Suspend held back until the latency has passed since a resume
  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      guard_r <= 32'h0;
    end else if (st_r == H_END && tick && op_r == OP_RESUME) begin
      guard_r <= 32'(GUARD_CYC);
    end else if (guard_r != 32'h0) begin
      guard_r <= guard_r - 32'h1;
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (RST_IN) begin
      st_r    <= H_IDLE;
      pend_r  <= 1'b0;
      csn_r   <= 1'b1;
      sclk_r  <= 1'b0;
      tx_r    <= 40'h0;
      rem_r   <= 6'h0;
      rx_r    <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (wr_r && wsel_r == REG_CMD && !pend_r) begin
            pend_r <= 1'b1;
          end else if (pend_r && !(op_r == OP_SUSPEND && guard_r != 32'h0)) begin
            st_r  <= H_SEND;
            csn_r <= 1'b0;
            tx_r  <= {op_r, addr_r, wdata_r};
            rem_r <= nbits;
          end
        end
        H_SEND: begin
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            rem_r  <= rem_r - (quad_r ? 6'd4 : 6'd1);
          end else if (tick) begin
            sclk_r <= 1'b0;
            if (rem_r == 6'h0) begin
              st_r  <= rd ? H_READ : H_END;
              rem_r <= 6'd8;
            end else begin
              tx_r <= quad_r ? {tx_r[35:0], 4'h0} : {tx_r[38:0], 1'b0};
            end
          end
        end
        H_READ: begin
          if (tick && !sclk_r) begin
            sclk_r <= 1'b1;
            rem_r  <= rem_r - (quad_r ? 6'd4 : 6'd1);
            rx_r   <= quad_r ? {rx_r[3:0], sy2_r} : {rx_r[6:0], sy2_r[1]};
          end else if (tick) begin
            sclk_r <= 1'b0;
            if (rem_r == 6'h0) begin
              st_r <= H_END;
            end
          end
        end
        H_END: begin
          if (tick) begin
            csn_r  <= 1'b1;
            st_r   <= H_IDLE;
            pend_r <= 1'b0;
            if (rd) begin
              rdata_r <= rx_r;
            end
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  assign LINK.sclk        = sclk_r;
  assign LINK.cs_n        = csn_r;
  assign LINK.host_io_out = quad_r ? tx_r[39:36] : {3'b000, tx_r[39]};
  assign LINK.host_io_oe  = (st_r == H_SEND) ? (quad_r ? 4'hf : 4'h1) : 4'h0;
endmodule

// [fesseq_chk.sv]
// Assertions on link framing and sequencer flags
`timescale 1ns/1ps
module fesseq_chk (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_IN,
  // Link
  input wire logic sclk,
  input wire logic cs_n,
  // Flags
  input wire logic BUSY_OUT,
  input wire logic WRITE_ENABLE_LATCH_OUT,
  input wire logic SUSPEND_FLAG_OUT,
  input wire logic ERASE_DONE_OUT
);
  wire busy = BUSY_OUT;
  wire write_enable_latch  = WRITE_ENABLE_LATCH_OUT;
  wire suspend_flag  = SUSPEND_FLAG_OUT;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (RST_IN);
  sequence s_susp; $rose(suspend_flag); endsequence
  property p_idle_clk; cs_n |-> !sclk; endproperty
  a_idle_clk: assert property (p_idle_clk) else $error("clock moves outside frame");
  property p_sus_busy; s_susp |-> busy && $past(busy); endproperty
  a_sus_busy: assert property (p_sus_busy) else $error("suspend taken while idle");
  property p_sus_lat; s_susp |-> ##[1:60] !busy; endproperty
  a_sus_lat: assert property (p_sus_lat) else $error("busy kept after suspend");
  property p_resume; $fell(suspend_flag) |-> ##[1:25] busy; endproperty
  a_resume: assert property (p_resume) else $error("busy not back after resume");
  property p_wel_clr; $fell(busy) && !suspend_flag |-> ##[0:1] !write_enable_latch; endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch kept after cycle");
  property p_done; ERASE_DONE_OUT |-> ##[0:1] !busy && !write_enable_latch; endproperty
  a_done: assert property (p_done) else $error("done while still running");
  property p_wel_set; $rose(write_enable_latch) |-> !$past(busy); endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch set while busy");
  property p_busy_start; $rose(busy) && !suspend_flag |-> write_enable_latch; endproperty
  a_busy_start: assert property (p_busy_start) else $error("cycle without latch");
endmodule

// [tb_top.sv]
// Testbench joining controller and sequencer
`timescale 1ns/1ps
module tb_top;
  import fesseq_pkg::*;
  logic clk = 0, rst = 1, rh = 0, fw = 0, hw = 0, pc = 0, sg = 0, tbp = 0, hs1 = 0;
  logic [2:0] bp = 0, hsz = 0;
  logic [1:0] ht = 0;
  logic [31:0] ha = 0, hwd = 0, hrd, rd = 0;
  logic hro, busy, write_enable_latch, suspend_flag, done;
  fesseq_op_t kind, dk;
  logic [23:0] base, db;
  int dn = 0, bad_count = 0, n_tests = 0, c0;
  wire [23:0] flg = {21'h0, suspend_flag, write_enable_latch, busy};
  // Rows: four-wire, opcode, address, expected base, expected kind
  localparam logic [59:0] ROWS [4] = '{{1'b1, OP_BLOCK32_ERASE, 24'h012345, 24'h010000, OPK_BLK32},
    {1'b0, OP_BLOCK64_ERASE, 24'h0abcde, 24'h0a0000, OPK_BLK64}, {1'b1, OP_CHIP_ERASE_A, 24'h0, 24'h0, OPK_CHIP},
    {1'b0, OP_CHIP_ERASE_B, 24'h0, 24'h0, OPK_CHIP}};
  always #5 clk = ~clk;
  fesseq_if fesseq_if_i ();
  // Short counts keep the run brief
  fesseq_dev #(.BLK32_CYC(300), .BLK64_CYC(400), .CHIP_CYC(500), .SUSP_CYC(50))
  fesseq_dev_i (.CLOCK_IN(clk), .RST_IN(rst), .LINK(fesseq_if_i), .PROTECT_COMPLEMENT_IN(pc),
    .SECTOR_GRANULARITY_PROTECT_IN(sg), .TOP_BOTTOM_PROTECT_IN(tbp), .BLOCK_PROTECT_IN(bp),
    .FOUR_WIRE_INSTRUCTION_MODE_IN(fw), .BUSY_OUT(busy), .WRITE_ENABLE_LATCH_OUT(write_enable_latch), .SUSPEND_FLAG_OUT(suspend_flag),
    .ERASE_DONE_OUT(done), .ERASE_KIND_OUT(kind), .ERASE_BASE_OUT(base));
  fesseq_host #(.GUARD_CYC(50)) fesseq_host_i (.CLOCK_IN(clk), .RST_IN(rst | rh), .HSEL_IN(hs1),
    .HADDR_IN(ha), .HTRANS_IN(ht), .HWRITE_IN(hw), .HSIZE_IN(hsz), .HWDATA_IN(hwd), .HREADY_IN(hro),
    .HRDATA_OUT(hrd), .HREADYOUT_OUT(hro), .HRESP_OUT(), .LINK(fesseq_if_i));
  fesseq_chk fesseq_chk_i (.CLOCK_IN(clk), .RST_IN(rst), .sclk(fesseq_if_i.sclk), .cs_n(fesseq_if_i.cs_n),
    .BUSY_OUT(busy), .WRITE_ENABLE_LATCH_OUT(write_enable_latch), .SUSPEND_FLAG_OUT(suspend_flag), .ERASE_DONE_OUT(done));
  always @(posedge clk) begin
    if (done === 1'b1) begin
      dn <= dn + 1;
      dk <= kind;
      db <= base;
    end
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hs1 <= 1'b1;
    hsz <= 3'h2;
    ht <= 2'h2;
    hw <= w;
    ha <= {24'h0, a};
    do @(posedge clk); while (hro !== 1'b1);
    ht <= 2'h0;
    hs1 <= 1'b0;
    hwd <= d;
    do @(posedge clk); while (hro !== 1'b1);
    rd = hrd;
  endtask
  // One frame, then wait until the link is quiet and the command has acted
  task cmd(input logic [7:0] o, input logic [23:0] a);
    xfer(1'b1, REG_ADDR, {8'h0, a});
    xfer(1'b1, REG_CMD, {24'h0, o});
    rd = 32'h1;
    for (int i = 0; i < 600 && rd[0] !== 1'b0; i++) xfer(1'b0, REG_STATUS, 32'h0);
    repeat (6) @(posedge clk);
  endtask
  task idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask
  task chk(input logic [23:0] g, input logic [23:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #600000;
    bad_count++;
    complete_run;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk(flg, 24'h0);
    foreach (ROWS[i]) begin
      fw <= ROWS[i][59];
      xfer(1'b1, REG_CFG, {31'h0, ROWS[i][59]});
      cmd(OP_WRITE_ENABLE, 24'h0);
      c0 = dn;
      cmd(ROWS[i][58:51], ROWS[i][50:27]);
      chk(flg, 24'h3);
      idle();
      chk(flg, 24'h0);
      chk(24'(dn - c0), 24'h1);
      chk({21'h0, dk}, {21'h0, ROWS[i][2:0]});
      chk(db, ROWS[i][26:3]);
      $display("row %0d done", i);
    end
    cmd(OP_BLOCK32_ERASE, 24'h0);
    chk(flg, 24'h0);
    bp <= 3'h1;
    cmd(OP_WRITE_ENABLE, 24'h0);
    cmd(OP_BLOCK32_ERASE, 24'h1f8000);
    chk(flg, 24'h2);
    cmd(OP_CHIP_ERASE_A, 24'h0);
    chk(flg, 24'h2);
    sg <= 1'b1;
    tbp <= 1'b1;
    cmd(OP_BLOCK32_ERASE, 24'h000000);
    chk(flg, 24'h2);
    pc <= 1'b1;
    cmd(OP_BLOCK32_ERASE, 24'h100000);
    chk(flg, 24'h2);
    pc <= 1'b0;
    sg <= 1'b0;
    tbp <= 1'b0;
    bp <= 3'h0;
    $display("refusals done");
    c0 = dn;
    cmd(OP_BLOCK64_ERASE, 24'h020000);
    cmd(OP_SUSPEND, 24'h0);
    chk(flg, 24'h7);
    idle();
    chk(flg, 24'h6);
    cmd(OP_BLOCK32_ERASE, 24'h100000);
    chk(flg, 24'h6);
    cmd(OP_RESUME, 24'h0);
    repeat (25) @(posedge clk);
    chk(flg, 24'h3);
    idle();
    chk(24'(dn - c0), 24'h1);
    chk({21'h0, dk}, {21'h0, OPK_BLK64});
    cmd(OP_SUSPEND, 24'h0);
    chk(flg, 24'h0);
    cmd(OP_WRITE_ENABLE, 24'h0);
    cmd(OP_CHIP_ERASE_B, 24'h0);
    cmd(OP_SUSPEND, 24'h0);
    chk(flg, 24'h3);
    cmd(OP_WRITE_DISABLE, 24'h0);
    chk(flg, 24'h3);
    idle();
    $display("suspend done");
    cmd(OP_WRITE_ENABLE, 24'h0);
    cmd(OP_PAGE_PROG, 24'h0);
    cmd(OP_SUSPEND, 24'h0);
    cmd(OP_QUAD_PROG, 24'h0);
    chk(flg, 24'h6);
    cmd(OP_WRITE_ENABLE, 24'h0);
    cmd(OP_SECTOR_ERASE, 24'h0);
    cmd(OP_SUSPEND, 24'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk(flg, 24'h0);
    // Host reset mid-frame leaves the device with a cut frame
    cmd(OP_WRITE_ENABLE, 24'h0);
    xfer(1'b1, REG_CMD, {24'h0, OP_BLOCK32_ERASE});
    repeat (200) @(posedge clk);
    rh <= 1'b1;
    @(posedge clk);
    rh <= 1'b0;
    repeat (20) @(posedge clk);
    chk(flg, 24'h2);
    $display("reset cases done");
    complete_run;
  end
endmodule
